// *** rtl/mie_decode.sv ***
module mie_decode (
    input wire logic [mie_pkg::INSTR_W-1:0] instr,
    output mie_pkg::mie_opkind_t kind
);
    import mie_pkg::*;
    always_comb begin
        kind = OPK_NONE;
        if (instr == OP_TIMER_CFG_LOAD) begin
            kind = OPK_TIMER_CFG;
        end else if (instr[OP4_HI:OP4_LO] == OP_LITERAL) begin
            kind = OPK_LITERAL;
        end else if (instr[OP6_HI:OP6_LO] == OP_INC_SKIP) begin
            kind = OPK_INC_SKIP;
        end else if (instr[OP6_HI:OP6_LO] == OP_FILE_MOVE) begin
            kind = OPK_FILE_MOVE;
        end else if (instr[OP6_HI:OP6_LO] == OP_OR_FILE) begin
            kind = OPK_OR_FILE;
        end else if (instr[OP6_HI:OP6_LO] == OP_STORE_GRP && instr[DEST_BIT]) begin
            kind = OPK_STORE;
        end
    end
endmodule

// *** rtl/mie_exec.sv ***
// Functional notes
// RL1: increment-skip adds one, flags untouched
// RL2: zero result turns next instruction into no-op
// RL3: destination bit 0 selects W, 1 file
// RL4: OR-with-file ORs W and register
// RL5: phases decode, read, process, write
// RL6: literal load writes W, flags untouched
// RL7: file move copies and updates zero flag
// RL8: store writes W into file register
// RL9: legacy opcode copies W to timer config
// RL10: timer config also reachable by file address
// RL11: OR-with-file sets zero flag on zero
module mie_exec (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [mie_pkg::INSTR_W-1:0] instr,
    output logic instrTaken,
    output logic [mie_pkg::DATA_W-1:0] accum,
    output logic zeroFlag,
    output logic [mie_pkg::DATA_W-1:0] timerCfg,
    output logic [1:0] phase,
    output logic skipActive
);
    import mie_pkg::*;

    typedef struct packed {
        mie_phase_t phase;
        logic [INSTR_W-1:0] ir;
        logic [DATA_W-1:0] opnd;
        logic [DATA_W-1:0] res;
        logic [DATA_W-1:0] accum;
        logic zero;
        logic [DATA_W-1:0] timerCfg;
        logic skipNext;
        logic squash;
        logic taken;
    } mie_state_t;

    // power-up state; the file array has no reset and starts unknown
    localparam mie_state_t STATE_RESET = '{
        phase: PH_DECODE,
        ir: '0,
        opnd: '0,
        res: '0,
        accum: '0,
        zero: 1'b0,
        timerCfg: TIMER_CFG_RESET,
        skipNext: 1'b0,
        squash: 1'b0,
        taken: 1'b0
    };

    mie_state_t cur_ff, nxt_cur;
    logic [DATA_W-1:0] fileMem [NUM_REGS];
    mie_opkind_t kind;
    logic [ADDR_W-1:0] addr;
    logic dest;
    logic atAlias;
    logic [DATA_W-1:0] fileRd;
    logic [DATA_W-1:0] opndSel;
    logic [DATA_W-1:0] aluOut;
    logic resZero;
    logic inWrite;
    logic wbAccum;
    logic wbFile;
    logic wbTimer;
    logic wbZero;
    logic wbSkip;
    logic fileWe;
    logic timerWe;
    logic [DATA_W-1:0] fileWd;
    mie_phase_t phaseNext;

    mie_decode u_decode (
        .instr(cur_ff.ir),
        .kind(kind)
    );

    assign addr = cur_ff.ir[ADDR_W-1:0];
    assign dest = cur_ff.ir[DEST_BIT];
    assign atAlias = (addr == TIMER_CFG_ADDR);

    // timer config aliased into file space
    always_comb begin
        if (atAlias) begin
            fileRd = cur_ff.timerCfg;
        end else begin
            fileRd = fileMem[addr];
        end
    end

    // RL6 literal stands in for the file operand
    always_comb begin
        if (kind == OPK_LITERAL) begin
            opndSel = cur_ff.ir[DATA_W-1:0];
        end else begin
            opndSel = fileRd;
        end
    end

    // result formed in the process phase, kept in res
    always_comb begin
        unique case (kind)
            // RL1 increment
            OPK_INC_SKIP: aluOut = cur_ff.opnd + DATA_ONE;
            // RL4 inclusive OR
            OPK_OR_FILE: aluOut = cur_ff.opnd | cur_ff.accum;
            OPK_STORE, OPK_TIMER_CFG: aluOut = cur_ff.accum;
            default: aluOut = cur_ff.opnd;
        endcase
    end

    // zero test on the stored result, shared by skip and flag
    assign resZero = (cur_ff.res == DATA_ZERO);

    // RL5 phase sequencing
    always_comb begin
        phaseNext = cur_ff.phase;
        unique case (cur_ff.phase)
            PH_DECODE: phaseNext = PH_READ;
            PH_READ: phaseNext = PH_PROCESS;
            PH_PROCESS: phaseNext = PH_WRITE;
            PH_WRITE: phaseNext = PH_DECODE;
        endcase
    end

    // a squashed word writes no W, file, flag, timer or skip state, so skips never chain
    assign inWrite = (cur_ff.phase == PH_WRITE) && !cur_ff.squash;

    always_comb begin
        wbAccum = 1'b0;
        wbFile = 1'b0;
        wbTimer = 1'b0;
        wbZero = 1'b0;
        wbSkip = 1'b0;
        if (inWrite) begin
            unique case (kind)
                OPK_INC_SKIP, OPK_OR_FILE, OPK_FILE_MOVE: begin
                    // RL3 destination select
                    wbFile = dest;
                    wbAccum = !dest;
                end
                // RL6 literal to W
                OPK_LITERAL: wbAccum = 1'b1;
                // RL8 store W
                OPK_STORE: wbFile = 1'b1;
                // RL9 legacy timer load
                OPK_TIMER_CFG: wbTimer = 1'b1;
                default: ;
            endcase
            // RL2 skip on zero
            wbSkip = (kind == OPK_INC_SKIP) && resZero;
            // RL7 RL11 zero flag
            wbZero = (kind == OPK_FILE_MOVE) || (kind == OPK_OR_FILE);
        end
    end

    // RL10 file write reaches timer config
    assign timerWe = wbTimer || (wbFile && atAlias);
    // aliased address kept out of the array so two copies cannot disagree
    assign fileWe = wbFile && !atAlias;
    assign fileWd = cur_ff.res;

    // fields move only in their own phase
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.phase = phaseNext;
        nxt_cur.taken = 1'b0;
        unique case (cur_ff.phase)
            PH_DECODE: begin
                nxt_cur.ir = instr;
                nxt_cur.taken = 1'b1;
                // a pending skip turns this word into a no-op
                nxt_cur.squash = cur_ff.skipNext;
                nxt_cur.skipNext = 1'b0;
            end
            PH_READ: begin
                nxt_cur.opnd = opndSel;
            end
            PH_PROCESS: begin
                nxt_cur.res = aluOut;
            end
            PH_WRITE: begin
                nxt_cur.squash = 1'b0;
                nxt_cur.skipNext = wbSkip;
            end
        endcase
        if (wbAccum) begin
            nxt_cur.accum = cur_ff.res;
        end
        // flags move only where the instruction names them
        if (wbZero) begin
            nxt_cur.zero = resZero;
        end
        if (timerWe) begin
            nxt_cur.timerCfg = cur_ff.res;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur_ff <= STATE_RESET;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // storage has no reset; a read before the first write returns unknown
    always_ff @(posedge clk) begin
        if (fileWe) begin
            fileMem[addr] <= fileWd;
        end
    end

    // every output is a state flop, nothing decoded after it
    assign instrTaken = cur_ff.taken;
    assign accum = cur_ff.accum;
    assign zeroFlag = cur_ff.zero;
    assign timerCfg = cur_ff.timerCfg;
    assign phase = cur_ff.phase;
    assign skipActive = cur_ff.squash;
endmodule

// *** rtl/mie_pkg.sv ***
package mie_pkg;
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int NUM_REGS = 128;
    // instruction field positions
    localparam int DEST_BIT = 7;
    localparam int OP6_HI = 13;
    localparam int OP6_LO = 8;
    localparam int OP4_HI = 13;
    localparam int OP4_LO = 10;
    // opcode encodings
    localparam logic [5:0] OP_INC_SKIP = 6'h0f;
    localparam logic [5:0] OP_FILE_MOVE = 6'h08;
    localparam logic [5:0] OP_OR_FILE = 6'h04;
    localparam logic [5:0] OP_STORE_GRP = 6'h00;
    localparam logic [3:0] OP_LITERAL = 4'hc;
    localparam logic [13:0] OP_TIMER_CFG_LOAD = 14'h0062;
    // file address that aliases the timer configuration register
    localparam logic [6:0] TIMER_CFG_ADDR = 7'h01;
    localparam logic [7:0] TIMER_CFG_RESET = 8'hff;
    localparam logic [7:0] DATA_ZERO = 8'h00;
    localparam logic [7:0] DATA_ONE = 8'h01;
    typedef enum logic [1:0] {
        PH_DECODE = 2'b00,
        PH_READ = 2'b01,
        PH_PROCESS = 2'b10,
        PH_WRITE = 2'b11
    } mie_phase_t;
    typedef enum logic [2:0] {
        OPK_NONE = 3'b000,
        OPK_INC_SKIP = 3'b001,
        OPK_OR_FILE = 3'b010,
        OPK_LITERAL = 3'b011,
        OPK_FILE_MOVE = 3'b100,
        OPK_STORE = 3'b101,
        OPK_TIMER_CFG = 3'b110
    } mie_opkind_t;
endpackage

// *** testbench/mie_exec_props.sv ***
module mie_exec_props (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [13:0] instr,
    input wire logic instrTaken,
    input wire logic [7:0] accum,
    input wire logic zeroFlag,
    input wire logic [7:0] timerCfg,
    input wire logic [1:0] phase,
    input wire logic skipActive
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // instruction sampled in phase 0 and not squashed
    sequence s_go(logic [13:0] m, logic [13:0] v);
        phase == 2'h0 && (instr & m) == v ##1 !skipActive;
    endsequence
    a_phase_walk: assert property (phase == 2'h0 |=> phase == 2'h1 ##1 phase == 2'h2 ##1 phase == 2'h3)
        else $error("phase walk");
    a_taken_phase: assert property (instrTaken |-> phase == 2'h1)
        else $error("taken phase");
    a_literal_load: assert property (s_go(14'h3c00, 14'h3000) |-> ##3 accum == $past(instr[7:0], 4))
        else $error("literal load");
    a_timer_load: assert property (s_go(14'h3fff, 14'h0062) |-> ##3 timerCfg == $past(accum, 4))
        else $error("timer load");
    a_inc_dest: assert property (s_go(14'h3fff, 14'h0f01) |-> ##3 accum == $past(timerCfg, 4) + 8'h01)
        else $error("inc dest");
    a_skip_zero: assert property (s_go(14'h3f80, 14'h0f00) |-> ##4 skipActive == (accum == 8'h00))
        else $error("skip zero");
    a_squash_hold: assert property (skipActive && phase == 2'h3 |=> $stable(accum) && $stable(zeroFlag))
        else $error("squash hold");
    a_or_zero: assert property (s_go(14'h3f80, 14'h0400) |-> ##3 zeroFlag == (accum == 8'h00))
        else $error("or zero");
endmodule

bind mie_exec mie_exec_props u_props (.clk(clk), .resetn(resetn), .instr(instr), .instrTaken(instrTaken),
    .accum(accum), .zeroFlag(zeroFlag), .timerCfg(timerCfg), .phase(phase), .skipActive(skipActive));

// *** testbench/mie_exec_tb.sv ***
module mie_exec_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [13:0] instr = 14'h0000;
    logic instrTaken, zeroFlag, skipActive;
    logic [7:0] accum, timerCfg;
    logic [1:0] phase;
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;
    always #25 clk = ~clk;
    mie_exec u_dut (.clk(clk), .resetn(resetn), .instr(instr), .instrTaken(instrTaken), .accum(accum),
        .zeroFlag(zeroFlag), .timerCfg(timerCfg), .phase(phase), .skipActive(skipActive));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // four clocks a word; result visible on return
    task automatic run(input logic [13:0] v);
        instr = v;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic t_timer();
        chk(timerCfg, 8'hff);
        run(14'h3033);
        run(14'h0062);
        chk(timerCfg, 8'h33);
        run(14'h3044);
        run(14'h0081);
        chk(timerCfg, 8'h44);
        run(14'h0f01);
        chk(accum, 8'h45);
        $display("done timer");
    endtask
    task automatic t_move();
        run(14'h304f);
        run(14'h00a0);
        run(14'h3000);
        run(14'h0820);
        chk(accum, 8'h4f);
        chk(8'(zeroFlag), 8'h00);
        run(14'h3000);
        run(14'h00a1);
        run(14'h08a1);
        run(14'h3077);
        chk(8'(zeroFlag), 8'h01);
        $display("done move");
    endtask
    task automatic t_or();
        run(14'h3013);
        run(14'h00a2);
        run(14'h3091);
        run(14'h0422);
        chk(accum, 8'h93);
        chk(8'(zeroFlag), 8'h00);
        run(14'h3000);
        run(14'h00a3);
        run(14'h04a3);
        chk(8'(zeroFlag), 8'h01);
        $display("done or");
    endtask
    task automatic t_skip();
        run(14'h30fe);
        run(14'h00a4);
        run(14'h0fa4);
        run(14'h3011);
        chk(accum, 8'h11);
        run(14'h0f24);
        chk(accum, 8'h00);
        instr = 14'h3022;
        @(posedge clk);
        #1;
        chk(8'(skipActive), 8'h01);
        repeat (3) @(posedge clk);
        #1;
        chk(accum, 8'h00);
        run(14'h0824);
        chk(accum, 8'hff);
        $display("done skip");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 1500) begin
            bad_count++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        #1 resetn = 1'b1;
        t_timer();
        t_move();
        t_or();
        t_skip();
        tally_and_finish();
    end
endmodule
